// file: logic/lrad_top.sv
// resonant actuator drive option bits and the drive they steer
// What this block does
// - control bit 2: amplitude refresh once (0) or twice (1) per cycle
// - input type bit steers the drive only while operating mode equals 3; it feeds the unsupported flag in every mode
// - input type 0 takes pin duty cycle, 1 takes pin analog level
// - fixed frequency bit 1 drives at set frequency, 0 auto-resonance
// - fixed drive from pulse input: commutation is pin frequency / 128
// - playback, library and audio modes use 7-bit period field
// - playback format bit: 0 signed values, 1 unsigned values
`timescale 1ns/1ps
module lrad_top #(
	parameter int UNIT_CYC = lrad_pkg::PERIOD_UNIT_CYC,
	parameter int DUTY_W = lrad_pkg::DUTY_WIN_W
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [lrad_pkg::ADDR_W-1:0] i_addr,
	input wire logic [lrad_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [lrad_pkg::DATA_W-1:0] o_rdata,
	input wire logic i_trig_pin,
	input wire logic [7:0] i_analog_level,
	input wire logic [7:0] i_playback_value,
	input wire logic [7:0] i_engine_level,
	input wire logic i_resonance_tick,
	output logic [7:0] o_amplitude,
	output logic o_polarity,
	output logic o_update,
	output logic o_unsupported
);
	generate
		if (DUTY_W < 8) begin : g_bad
			$error("duty window must span at least 256 cycles");
		end
	endgenerate

	logic [3:0] ctrl;
	logic [lrad_pkg::MODE_W-1:0] mode;
	logic [lrad_pkg::PERIOD_W-1:0] period;
	logic pin_s1;
	logic pin_s2;
	logic pin_d;
	logic [DUTY_W-1:0] win_cnt;
	logic [DUTY_W:0] high_cnt;
	logic [7:0] duty;
	logic [7:0] next_src_level;
	logic [7:0] next_rdata;
	lrad_tmr_if tmr_bus ();

	function automatic logic is_addr(input logic [3:0] a, input logic [3:0] o);
		return a == o;
	endfunction

	wire fixed_freq = ctrl[lrad_pkg::BIT_FIXED_FREQ];
	wire analog_sel = ctrl[lrad_pkg::BIT_INPUT_TYPE];
	wire twice_rate = ctrl[lrad_pkg::BIT_UPDATE_RATE];
	wire unsigned_fmt = ctrl[lrad_pkg::BIT_SIGNEDNESS];
	// input type honoured only in pin mode
	wire pin_mode = (mode == lrad_pkg::MODE_PIN);
	wire pin_analog = pin_mode && analog_sel;
	wire pin_rise = pin_s2 && !pin_d;
	wire win_end = &win_cnt;
	wire [DUTY_W:0] sat_high = high_cnt + (DUTY_W+1)'(pin_s2);

	// signed values clip below zero, positive doubled
	wire [7:0] play_level = unsigned_fmt ? i_playback_value :
		(i_playback_value[7] ? 8'h00 : {i_playback_value[6:0], 1'b0});

	always_comb begin
		next_src_level = i_engine_level;
		if (pin_mode) begin
			next_src_level = pin_analog ? i_analog_level : duty;
		end else if (mode == lrad_pkg::MODE_PLAYBACK) begin
			next_src_level = play_level;
		end
	end

	assign tmr_bus.src = !fixed_freq ? lrad_pkg::SRC_RESONANCE :
		(pin_mode && !analog_sel) ? lrad_pkg::SRC_PIN :
		lrad_pkg::SRC_PERIOD;
	assign tmr_bus.pin_rise = pin_rise;
	assign tmr_bus.res_tick = i_resonance_tick;
	assign tmr_bus.period = period;

	lrad_half_timer #(
		.UNIT_CYC(UNIT_CYC),
		.EDGES(lrad_pkg::EDGES_PER_HALF)
	) u_timer (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.bus(tmr_bus.tmr)
	);

	// refresh on every half or on full cycles
	wire do_update = tmr_bus.half_tick && (twice_rate || o_polarity);

	always_comb begin
		next_rdata = 8'h00;
		if (is_addr(i_addr, lrad_pkg::OFF_CTRL))
			next_rdata = {4'h0, ctrl};
		else if (is_addr(i_addr, lrad_pkg::OFF_MODE))
			next_rdata = {5'h00, mode};
		else if (is_addr(i_addr, lrad_pkg::OFF_PERIOD))
			next_rdata = {1'b0, period};
		else if (is_addr(i_addr, lrad_pkg::OFF_STATUS))
			next_rdata = {4'h0, tmr_bus.src, o_polarity, o_unsupported};
		else if (is_addr(i_addr, lrad_pkg::OFF_AMPL))
			next_rdata = o_amplitude;
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ctrl <= lrad_pkg::CTRL_RST;
			mode <= lrad_pkg::MODE_RST;
			period <= lrad_pkg::PERIOD_RST;
		end else if (i_wr) begin
			if (is_addr(i_addr, lrad_pkg::OFF_CTRL))
				ctrl <= i_wdata[3:0];
			if (is_addr(i_addr, lrad_pkg::OFF_MODE))
				mode <= i_wdata[2:0];
			if (is_addr(i_addr, lrad_pkg::OFF_PERIOD))
				period <= i_wdata[6:0];
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			o_rdata <= 8'h00;
		else
			o_rdata <= i_rd ? next_rdata : 8'h00;
	end

	// pin is asynchronous to the clock
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pin_s1 <= 1'b0;
			pin_s2 <= 1'b0;
			pin_d <= 1'b0;
		end else begin
			pin_s1 <= i_trig_pin;
			pin_s2 <= pin_s1;
			pin_d <= pin_s2;
		end
	end

	// duty over a fixed window, no divider needed; 256 high reads 255
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			win_cnt <= '0;
			high_cnt <= '0;
			duty <= 8'h00;
		end else begin
			win_cnt <= win_cnt + DUTY_W'(1);
			high_cnt <= win_end ? '0 : sat_high;
			if (win_end)
				duty <= sat_high[DUTY_W] ? 8'hff :
					sat_high[DUTY_W-1 -: 8];
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_amplitude <= 8'h00;
			o_polarity <= 1'b0;
			o_update <= 1'b0;
			o_unsupported <= 1'b0;
		end else begin
			if (tmr_bus.half_tick)
				o_polarity <= !o_polarity;
			if (do_update)
				o_amplitude <= next_src_level;
			o_update <= do_update;
			// flag the combination software must avoid
			o_unsupported <= fixed_freq && analog_sel;
		end
	end
endmodule

// file: logic/lrad_pkg.sv
// constants and types of the resonant drive option block
package lrad_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam logic [3:0] OFF_CTRL = 4'h0;
	localparam logic [3:0] OFF_MODE = 4'h1;
	localparam logic [3:0] OFF_PERIOD = 4'h2;
	localparam logic [3:0] OFF_STATUS = 4'h3;
	localparam logic [3:0] OFF_AMPL = 4'h4;
	localparam int BIT_FIXED_FREQ = 0;
	localparam int BIT_INPUT_TYPE = 1;
	localparam int BIT_UPDATE_RATE = 2;
	localparam int BIT_SIGNEDNESS = 3;
	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam logic [2:0] MODE_RST = 3'h0;
	localparam logic [6:0] PERIOD_RST = 7'h00;
	localparam int MODE_W = 3;
	localparam int PERIOD_W = 7;
	localparam logic [2:0] MODE_LIBRARY = 3'h0;
	localparam logic [2:0] MODE_PIN = 3'h3;
	localparam logic [2:0] MODE_AUDIO = 3'h4;
	localparam logic [2:0] MODE_PLAYBACK = 3'h5;
	localparam int PIN_DIVIDE = 128;
	localparam int EDGES_PER_HALF = PIN_DIVIDE / 2;
	localparam int CLK_PERIOD_NS = 10;
	localparam int PERIOD_UNIT_NS = 1000;
	localparam int PERIOD_UNIT_CYC = (PERIOD_UNIT_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int DUTY_WIN_W = 8;
	typedef enum logic [1:0] {
		SRC_RESONANCE,
		SRC_PIN,
		SRC_PERIOD
	} lrad_src_e;
endpackage

// file: logic/lrad_tmr_if.sv
// carrier between the option block and its half-cycle timer
`timescale 1ns/1ps
interface lrad_tmr_if;
	lrad_pkg::lrad_src_e src;
	logic pin_rise;
	logic res_tick;
	logic [lrad_pkg::PERIOD_W-1:0] period;
	logic half_tick;
	modport ctl (output src, output pin_rise, output res_tick,
		output period, input half_tick);
	modport tmr (input src, input pin_rise, input res_tick,
		input period, output half_tick);
endinterface

// file: logic/lrad_half_timer.sv
// half drive cycle tick from pin edges, period field or resonance
`timescale 1ns/1ps
module lrad_half_timer #(
	parameter int UNIT_CYC = lrad_pkg::PERIOD_UNIT_CYC,
	parameter int EDGES = lrad_pkg::EDGES_PER_HALF
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	lrad_tmr_if.tmr bus
);
	localparam int UW = (UNIT_CYC > 1) ? $clog2(UNIT_CYC) : 1;
	localparam int EW = (EDGES > 1) ? $clog2(EDGES) : 1;
	generate
		if (UNIT_CYC < 1 || EDGES < 1) begin : g_bad
			$error("timer counts must be at least one");
		end
	endgenerate

	logic [UW-1:0] unit_cnt;
	logic [lrad_pkg::PERIOD_W-1:0] per_cnt;
	logic [EW-1:0] edge_cnt;
	logic next_tick;
	wire unit_wrap = (unit_cnt == UW'(UNIT_CYC - 1));
	wire per_wrap = unit_wrap && (per_cnt == bus.period - 7'h01);
	wire edge_wrap = bus.pin_rise && (edge_cnt == EW'(EDGES - 1));

	always_comb begin
		case (bus.src)
			lrad_pkg::SRC_RESONANCE: next_tick = bus.res_tick;
			lrad_pkg::SRC_PIN: next_tick = edge_wrap;
			lrad_pkg::SRC_PERIOD: next_tick = per_wrap &&
				(bus.period != 7'h00);
			default: next_tick = 1'b0;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			unit_cnt <= '0;
			per_cnt <= '0;
			edge_cnt <= '0;
			bus.half_tick <= 1'b0;
		end else begin
			unit_cnt <= unit_wrap ? '0 : unit_cnt + UW'(1);
			if (per_wrap || (unit_wrap && per_cnt >= bus.period))
				per_cnt <= '0;
			else if (unit_wrap)
				per_cnt <= per_cnt + 7'h01;
			if (bus.pin_rise)
				edge_cnt <= edge_wrap ? '0 : edge_cnt + EW'(1);
			bus.half_tick <= next_tick;
		end
	end
endmodule

// file: bench/lrad_chk.sv
// port assertions of the drive option block
`timescale 1ns/1ps
module lrad_chk (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic i_resonance_tick,
	input wire logic [7:0] o_amplitude,
	input wire logic o_polarity,
	input wire logic o_update,
	input wire logic o_unsupported
);
	logic [3:0] c;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	// shadow of the control register, kept from the bus
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			c <= 4'h0;
		else if (i_wr && i_addr == 4'h0)
			c <= i_wdata[3:0];
	end
	property p_unsup; o_unsupported == &$past(c[1:0]); endproperty
	a_unsup: assert property (p_unsup) else $error("bad flag");
	property p_rdz; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
	a_rdz: assert property (p_rdz) else $error("stray data");
	property p_rdc;
		i_rd && i_addr == 4'h0 |=> o_rdata == {4'h0, $past(c)};
	endproperty
	a_rdc: assert property (p_rdc) else $error("bad ctrl");
	property p_hold;
		!o_update |-> o_amplitude == $past(o_amplitude);
	endproperty
	a_hold: assert property (p_hold) else $error("amp moved");
	property p_utog; o_update |-> o_polarity != $past(o_polarity); endproperty
	a_utog: assert property (p_utog) else $error("off tick");
	property p_uhalf;
		o_update && !$past(c[2]) && !$past(c[2], 2) |-> !o_polarity;
	endproperty
	a_uhalf: assert property (p_uhalf) else $error("twice");
	property p_rtog;
		i_resonance_tick && !c[0] |-> ##2 o_polarity != $past(o_polarity);
	endproperty
	a_rtog: assert property (p_rtog) else $error("no toggle");
	property p_ronly;
		o_polarity != $past(o_polarity) && !$past(c[0], 2)
			&& !$past(c[0], 3) |-> $past(i_resonance_tick, 2);
	endproperty
	a_ronly: assert property (p_ronly) else $error("stray");
endmodule
bind lrad_top lrad_chk chk (.i_clk(i_clk), .i_rst_b(i_rst_b),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
	.o_rdata(o_rdata), .i_resonance_tick(i_resonance_tick),
	.o_amplitude(o_amplitude), .o_polarity(o_polarity),
	.o_update(o_update), .o_unsupported(o_unsupported));

// file: bench/lrad_pin_src.sv
// signal source on the trigger pin: 8 clock period, 2 high
`timescale 1ns/1ps
module lrad_pin_src (
	input wire logic i_clk,
	input wire logic i_en,
	output logic o_pin = 1'b0
);
	int n = 0;
	always @(posedge i_clk) begin
		n <= i_en ? (n + 1) % 8 : 0;
		o_pin <= i_en && n < 2;
	end
endmodule

// file: bench/lrad_tb_top.sv
// self-checking bench of the drive option block
`timescale 1ns/1ps
module lrad_tb_top;
	localparam int UC = 2;
	localparam logic [2:0] MS [5] = '{3'h0, 3'h4, 3'h3, 3'h5, 3'h5};
	localparam logic [3:0] CS [5] = '{4'h2, 4'h2, 4'h2, 4'h0, 4'h8};
	logic i_clk = 0, i_rst_b = 0, i_wr = 0, i_rd = 0, tick = 0, pen = 0;
	logic [3:0] i_addr = 4'h0;
	logic [7:0] i_wdata = 8'h00, an = 8'h00, pv = 8'h00, en = 8'h00;
	logic [7:0] o_rdata, amp;
	logic pin, pol, upd, uns;
	int error_cnt = 0, num_checks = 0, cyc = 0, upd_n = 0, seed = 36;
	lrad_top #(.UNIT_CYC(UC)) uut (.i_clk(i_clk), .i_rst_b(i_rst_b),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_trig_pin(pin), .i_analog_level(an),
		.i_playback_value(pv), .i_engine_level(en),
		.i_resonance_tick(tick), .o_amplitude(amp), .o_polarity(pol),
		.o_update(upd), .o_unsupported(uns));
	lrad_pin_src src (.i_clk(i_clk), .i_en(pen), .o_pin(pin));
	always #5 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (upd === 1'b1)
			upd_n <= upd_n + 1;
		if (cyc == 20000) begin
			error_cnt++;
			end_of_test();
		end
	end
	task automatic ck(logic [15:0] g, logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic wr(logic [3:0] a, logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(logic [3:0] a, logic [7:0] e);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 ck(16'(o_rdata), 16'(e));
	endtask
	task automatic tk(int n);
		repeat (n) begin
			@(posedge i_clk);
			tick <= 1'b1;
			@(posedge i_clk);
			tick <= 1'b0;
			repeat (3) @(posedge i_clk);
		end
	endtask
	task automatic tog(output int t);
		logic p;
		p = pol;
		for (int i = 0; i < 1200 && pol === p; i++) begin
			@(posedge i_clk);
			#1;
		end
		t = cyc;
	endtask
	task automatic gap(int e);
		int a, b;
		tog(a);
		tog(b);
		ck(16'(b - a), 16'(e));
	endtask
	// expected drive amplitude, duty 2 of 8 gives 0x40
	function automatic logic [7:0] model(logic [2:0] m, logic [3:0] c);
		if (m == 3'h3)
			return c[1] ? an : 8'h40;
		if (m != 3'h5)
			return en;
		if (c[3])
			return pv;
		return pv[7] ? 8'h00 : {pv[6:0], 1'b0};
	endfunction
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		int n;
		repeat (2) @(posedge i_clk);
		i_rst_b <= 1'b1;
		for (int a = 0; a < 3; a++)
			rd(4'(a), 8'h00);
		wr(4'hf, 8'hff);
		rd(4'hf, 8'h00);
		wr(4'h0, 8'h03);
		rd(4'h3, 8'h09);
		ck(16'(uns), 16'h0001);
		$display("register test done");
		for (int i = 0; i < 5; i++) begin
			wr(4'h1, {5'h00, MS[i]});
			wr(4'h0, {4'h0, CS[i]});
			an <= 8'($random(seed));
			pv <= 8'($random(seed));
			en <= 8'($random(seed));
			repeat (4) @(posedge i_clk);
			tk(2);
			ck(16'(amp), 16'(model(MS[i], CS[i])));
		end
		$display("source test done");
		for (int r = 0; r < 2; r++) begin
			wr(4'h0, r ? 8'h04 : 8'h00);
			n = upd_n;
			tk(8);
			ck(16'(upd_n - n), r ? 16'h0008 : 16'h0004);
		end
		wr(4'h2, 8'h85);
		wr(4'h0, 8'h01);
		rd(4'h2, 8'h05);
		gap(5 * UC);
		$display("rate and period test done");
		wr(4'h1, 8'h03);
		pen <= 1'b1;
		// first toggle may carry a duty window from before the pin ran
		tog(n);
		gap(64 * 8);
		ck(16'(amp), 16'(model(3'h3, 4'h1)));
		$display("pin test done");
		end_of_test();
	end
endmodule
